// ---- hw/swdst_pkg.sv ----
// types shared by the supervisor timer block
package swdst_pkg;
  typedef logic [7:0]  swdst_byte_t;
  typedef logic [1:0]  swdst_idx_t;
  typedef logic [13:0] swdst_ms_t;
  typedef enum logic { RST_HOLD, RST_RUN } swdst_rst_state_t;
endpackage

// ---- hw/swdst_regs.svh ----
// register map, field positions, reset values and timing counts
`ifndef SWDST_REGS_SVH
`define SWDST_REGS_SVH

// register indices on the link
`define SWDST_IDX_CFG        2'h0
`define SWDST_IDX_WDCTRL     2'h1
`define SWDST_IDX_CTRL1      2'h2
`define SWDST_IDX_STATUS     2'h3

// interval config / refresh control fields
`define SWDST_BIT_ENABLE     7
`define SWDST_BIT_REFRESH    7
`define SWDST_BIT_X1S        6
`define SWDST_BIT_X100MS     5
`define SWDST_BIT_X10MS      4
`define SWDST_BCD_MAX        4'hA

// control register 1 fields
`define SWDST_BIT_SOFTRST    7
`define SWDST_BIT_SELFTEST   6
`define SWDST_BIT_OLDIS      1
`define SWDST_BIT_DRVON      0

// reset values and implemented status bit mask
`define SWDST_CFG_RESET      8'hCA
`define SWDST_WDCTRL_RESET   8'h00
`define SWDST_CTRL1_RESET    8'h00
`define SWDST_STATUS_RESET   8'h00
`define SWDST_STATUS_IMPL    8'h7F

// timing
`define SWDST_CLK_PERIOD_NS  20
`define SWDST_TICK_NS        1000000
`define SWDST_HOLD_MS        10

`endif

// ---- hw/swdst_top.sv ----
// supervisor timer with status self-test, link and core domains
//
// Operation
// RULE1: supply-up reset loads defaults, outputs off, open-load detect enabled.
// RULE2: after any host reset pulse, timer enabled with ten second interval.
// RULE3: self-test bit six disconnects status from internal fault sources.
// RULE4: in self-test, status writes store ones and zeros as written.
// RULE5: outside self-test, writes only clear; only faults set bits.
// RULE6: clearing self-test returns status to defaults, reconnects faults.
// RULE7: timeout reset also clears the self-test bit.
// RULE8: host finishes self-test and first refresh within ten seconds.
// RULE9: unimplemented status bits have no storage and read zero.
// RULE10: each refresh reloads the interval and restarts timing from zero.
// RULE11: enabled timer expiring without refresh pulses host reset low.
// RULE12: count field reads 1 to 10; 0 means 1, above 10 means 10.
// RULE13: multipliers 1 s, 100 ms, 10 ms; largest set one wins.
// RULE14: config bit seven enables; zero gives no timeout resets.
// RULE15: refresh only on write with control bit seven set.
// RULE16: nonzero control bits six to zero give a one-shot interval.
// RULE17: control register clears itself whenever the timer loads.
// RULE18: after power valid, host reset held low for the hold period.
// RULE19: logic undervoltage or battery overvoltage also pulses host reset.
// RULE20: internal reset bit reloads all registers, pin untouched.
// RULE21: millisecond tick counted against count times multiplier at load.
// RULE22: no multiplier bit set means one millisecond units.
`include "swdst_regs.svh"

module swdst_top #(
  parameter int TICK_CYCLES = `SWDST_TICK_NS / `SWDST_CLK_PERIOD_NS,
  parameter int HOLD_MS     = `SWDST_HOLD_MS
) (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               linkClk,
  input  wire logic               linkResetn,
  input  wire logic               linkWrEn,
  input  wire logic               linkRdEn,
  input  wire swdst_pkg::swdst_idx_t  linkAddr,
  input  wire swdst_pkg::swdst_byte_t linkWrData,
  output logic                    linkBusy,
  output logic                    linkRdValid,
  output swdst_pkg::swdst_byte_t  linkRdData,
  input  wire swdst_pkg::swdst_byte_t faultIn,
  input  wire logic               vccUnderVoltage,
  input  wire logic               batteryOverVoltage,
  output logic                    hostResetOut,
  output logic                    hostResetOe,
  output logic                    loadDriveEnable,
  output logic                    openLoadDetectEnable
);
  import swdst_pkg::*;

  // decodes a 7-bit interval field into milliseconds
  function automatic swdst_ms_t intervalMs(input logic [6:0] code);
    logic [3:0] cnt;
    swdst_ms_t  mult;
    cnt  = code[3:0];
    mult = 14'd1;
    if (cnt == 4'h0) begin
      cnt = 4'h1; // see RULE12
    end else if (cnt > `SWDST_BCD_MAX) begin
      cnt = `SWDST_BCD_MAX; // see RULE12
    end
    if (code[`SWDST_BIT_X1S]) begin
      mult = 14'd1000; // see RULE13
    end else if (code[`SWDST_BIT_X100MS]) begin
      mult = 14'd100;
    end else if (code[`SWDST_BIT_X10MS]) begin
      mult = 14'd10;
    end
    // mult stays 1 with no multiplier: see RULE22
    intervalMs = swdst_ms_t'(cnt * mult);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // link domain: request capture and answer

  logic        reqTgl_q;
  logic        reqRd_q;
  swdst_idx_t  reqAddr_q;
  swdst_byte_t reqData_q;
  logic        busy_q;
  logic        rdValid_q;
  swdst_byte_t rdData_q;
  logic        ackS1_q, ackS2_q, ackS3_q, ackSeen_q;
  logic        ackTgl_q;
  swdst_byte_t rspData_q;

  // three-stage sync of the core acknowledge toggle
  always_ff @(posedge linkClk) begin
    if (!linkResetn) begin
      ackS1_q <= 1'b0;
      ackS2_q <= 1'b0;
      ackS3_q <= 1'b0;
    end else begin
      ackS1_q <= ackTgl_q;
      ackS2_q <= ackS1_q;
      ackS3_q <= ackS2_q;
    end
  end

  logic ackEvent;
  assign ackEvent = (ackS2_q == ackS3_q) && (ackS3_q != ackSeen_q);

  // one request in flight; held stable until acknowledged
  always_ff @(posedge linkClk) begin
    if (!linkResetn) begin
      reqTgl_q  <= 1'b0;
      reqRd_q   <= 1'b0;
      reqAddr_q <= 2'h0;
      reqData_q <= 8'h00;
      busy_q    <= 1'b0;
      ackSeen_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q  <= 8'h00;
    end else begin
      rdValid_q <= 1'b0;
      if (ackEvent) begin
        ackSeen_q <= ackS3_q;
        busy_q    <= 1'b0;
        if (reqRd_q) begin
          rdValid_q <= 1'b1;
          rdData_q  <= rspData_q;
        end
      end else if (!busy_q && (linkWrEn || linkRdEn)) begin
        reqTgl_q  <= ~reqTgl_q;
        reqRd_q   <= linkRdEn && !linkWrEn;
        reqAddr_q <= linkAddr;
        reqData_q <= linkWrData;
        busy_q    <= 1'b1;
      end
    end
  end

  assign linkBusy    = busy_q;
  assign linkRdValid = rdValid_q;
  assign linkRdData  = rdData_q;

  //////////////////////////////////////////////////////////////////////////
  // core domain: input synchronisers

  logic        reqS1_q, reqS2_q, reqS3_q, reqSeen_q;
  logic [9:0]  pinS1_q, pinS2_q, pinS3_q, pinOk_q;

  // request toggle through three flops; fault and supply pins through three plus an agreement filter flop
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reqS1_q <= 1'b0;
      reqS2_q <= 1'b0;
      reqS3_q <= 1'b0;
      pinS1_q <= 10'h000;
      pinS2_q <= 10'h000;
      pinS3_q <= 10'h000;
      pinOk_q <= 10'h000;
    end else begin
      reqS1_q <= reqTgl_q;
      reqS2_q <= reqS1_q;
      reqS3_q <= reqS2_q;
      pinS1_q <= {batteryOverVoltage, vccUnderVoltage, faultIn};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      for (int i = 0; i < 10; i++) begin
        if (pinS2_q[i] == pinS3_q[i]) begin
          pinOk_q[i] <= pinS3_q[i];
        end
      end
    end
  end

  logic        reqEvent;
  logic        wrCfg, wrWdCtrl, wrCtrl1, wrStatus;
  assign reqEvent = (reqS2_q == reqS3_q) && (reqS3_q != reqSeen_q);
  assign wrCfg    = reqEvent && !reqRd_q && reqAddr_q == `SWDST_IDX_CFG;
  assign wrWdCtrl = reqEvent && !reqRd_q && reqAddr_q == `SWDST_IDX_WDCTRL;
  assign wrCtrl1  = reqEvent && !reqRd_q && reqAddr_q == `SWDST_IDX_CTRL1;
  assign wrStatus = reqEvent && !reqRd_q && reqAddr_q == `SWDST_IDX_STATUS;

  //////////////////////////////////////////////////////////////////////////
  // core domain: reset sequencing and timer

  localparam int TW = $clog2(TICK_CYCLES + 1);

  swdst_rst_state_t rstState_q;
  logic [TW-1:0]    tickCnt_q;
  logic             tick;
  swdst_ms_t        holdMs_q;
  swdst_ms_t        elapsedMs_q;
  swdst_ms_t        intervalMs_q;
  swdst_byte_t      cfg_q, wdCtrl_q, ctrl1_q, status_q;
  logic             timeout, supplyFault, pulseStart, softReset, regInit;
  logic             refresh;
  logic [6:0]       loadCode;

  assign tick = (tickCnt_q == TW'(TICK_CYCLES - 1));
  assign timeout = rstState_q == RST_RUN && cfg_q[`SWDST_BIT_ENABLE] &&
                   tick && (elapsedMs_q + 14'd1 >= intervalMs_q);
  // see RULE14 (enable gate) and RULE11 (expiry)
  assign supplyFault = pinOk_q[8] || pinOk_q[9]; // see RULE19
  assign pulseStart  = rstState_q == RST_RUN && (timeout || supplyFault);
  assign softReset   = wrCtrl1 && reqData_q[`SWDST_BIT_SOFTRST]; // see RULE20
  assign regInit     = pulseStart || softReset; // see RULE2, RULE7
  assign refresh     = wrWdCtrl && reqData_q[`SWDST_BIT_REFRESH]; // see RULE15

  // one-shot interval: fresh bits, then pending bits, else the config
  always_comb begin
    if (reqData_q[6:0] != 7'h00) begin
      loadCode = reqData_q[6:0]; // see RULE16
    end else if (wdCtrl_q[6:0] != 7'h00) begin
      loadCode = wdCtrl_q[6:0];
    end else begin
      loadCode = cfg_q[6:0];
    end
  end

  // millisecond tick prescaler
  always_ff @(posedge ref_clk) begin
    if (!resetn || tick) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + TW'(1); // see RULE21
    end
  end

  // host reset hold and pulse sequencing
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rstState_q <= RST_HOLD; // see RULE18
      holdMs_q   <= '0;
    end else begin
      case (rstState_q)
        RST_HOLD: begin
          if (tick) begin
            if (holdMs_q >= 14'(HOLD_MS - 1)) begin
              rstState_q <= RST_RUN;
              holdMs_q   <= '0;
            end else begin
              holdMs_q <= holdMs_q + 14'd1;
            end
          end
        end
        RST_RUN: begin
          if (pulseStart) begin
            rstState_q <= RST_HOLD; // see RULE11, RULE19
          end
        end
        default: begin
          rstState_q <= RST_HOLD;
        end
      endcase
    end
  end

  // interval load and elapsed count
  always_ff @(posedge ref_clk) begin
    if (!resetn || regInit) begin
      intervalMs_q <= intervalMs(7'(`SWDST_CFG_RESET)); // see RULE2
      elapsedMs_q  <= '0;
    end else if (refresh) begin
      intervalMs_q <= intervalMs(loadCode); // see RULE10
      elapsedMs_q  <= '0;
    end else if (rstState_q != RST_RUN || !cfg_q[`SWDST_BIT_ENABLE]) begin
      elapsedMs_q <= '0;
    end else if (tick) begin
      elapsedMs_q <= elapsedMs_q + 14'd1; // see RULE21
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: registers

  // interval config register
  always_ff @(posedge ref_clk) begin
    if (!resetn || regInit) begin
      cfg_q <= `SWDST_CFG_RESET; // see RULE1, RULE2
    end else if (wrCfg) begin
      cfg_q <= reqData_q;
    end
  end

  // refresh control register, cleared on every timer load
  always_ff @(posedge ref_clk) begin
    if (!resetn || regInit || refresh) begin
      wdCtrl_q <= `SWDST_WDCTRL_RESET; // see RULE17
    end else if (wrWdCtrl) begin
      wdCtrl_q <= reqData_q;
    end
  end

  // control register 1, soft reset bit never stored
  always_ff @(posedge ref_clk) begin
    if (!resetn || regInit) begin
      ctrl1_q <= `SWDST_CTRL1_RESET; // see RULE7, RULE20
    end else if (wrCtrl1) begin
      ctrl1_q <= reqData_q;
      ctrl1_q[`SWDST_BIT_SOFTRST] <= 1'b0;
    end
  end

  logic selfTest, selfTestExit;
  assign selfTest     = ctrl1_q[`SWDST_BIT_SELFTEST];
  assign selfTestExit = wrCtrl1 && selfTest &&
                        !reqData_q[`SWDST_BIT_SELFTEST];

  // status register: faults set, host clears; self-test stores raw
  always_ff @(posedge ref_clk) begin
    if (!resetn || regInit || selfTestExit) begin
      status_q <= `SWDST_STATUS_RESET; // see RULE6
    end else if (selfTest) begin
      if (wrStatus) begin
        status_q <= reqData_q & `SWDST_STATUS_IMPL; // see RULE4, RULE9
      end
      // fault inputs ignored here: see RULE3
    end else begin
      status_q <= ((wrStatus ? (status_q & reqData_q) : status_q) |
                   pinOk_q[7:0]) & `SWDST_STATUS_IMPL; // see RULE5
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: answer and outputs

  // read snapshot and acknowledge toggle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reqSeen_q <= 1'b0;
      ackTgl_q  <= 1'b0;
      rspData_q <= 8'h00;
    end else if (reqEvent) begin
      reqSeen_q <= reqS3_q;
      ackTgl_q  <= ~ackTgl_q;
      case (reqAddr_q)
        `SWDST_IDX_CFG:    rspData_q <= cfg_q;
        `SWDST_IDX_WDCTRL: rspData_q <= wdCtrl_q;
        `SWDST_IDX_CTRL1:  rspData_q <= ctrl1_q;
        default:           rspData_q <= status_q;
      endcase
    end
  end

  logic hostRstOe_q, hostRstOut_q, drvEn_q, olEn_q;

  // open-drain host reset and output gating
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hostRstOe_q  <= 1'b1; // see RULE18
      hostRstOut_q <= 1'b0;
      drvEn_q      <= 1'b0; // see RULE1
      olEn_q       <= 1'b1;
    end else begin
      hostRstOe_q  <= pulseStart ||
                      (rstState_q == RST_HOLD &&
                       !(tick && holdMs_q >= 14'(HOLD_MS - 1)));
      hostRstOut_q <= 1'b0;
      drvEn_q      <= ctrl1_q[`SWDST_BIT_DRVON] &&
                      rstState_q == RST_RUN && !pulseStart;
      olEn_q       <= !ctrl1_q[`SWDST_BIT_OLDIS];
    end
  end

  assign hostResetOe          = hostRstOe_q;
  assign hostResetOut         = hostRstOut_q;
  assign loadDriveEnable      = drvEn_q;
  assign openLoadDetectEnable = olEn_q;

endmodule

// ---- verification/swdst_host_model.sv ----
// host model issuing one link request at a time
module swdst_host_model (
  input  wire logic                   linkClk,
  input  wire logic                   linkBusy,
  input  wire swdst_pkg::swdst_byte_t linkRdData,
  output logic                        linkWrEn,
  output logic                        linkRdEn,
  output swdst_pkg::swdst_idx_t       linkAddr,
  output swdst_pkg::swdst_byte_t      linkWrData
);
  timeunit 1ns;
  timeprecision 100ps;
  import swdst_pkg::*;
  // idle bus at time zero
  initial begin
    linkWrEn = 1'b0;
    linkRdEn = 1'b0;
    linkAddr = 2'h0;
    linkWrData = 8'h00;
  end
  // request held to the taking edge, then released
  task automatic xfer(input logic wr, input swdst_idx_t a,
                      input swdst_byte_t d, output swdst_byte_t q);
    int n;
    @(posedge linkClk);
    linkWrEn <= wr;
    linkRdEn <= ~wr;
    linkAddr <= a;
    linkWrData <= d;
    @(posedge linkClk);
    linkWrEn <= 1'b0;
    linkRdEn <= 1'b0;
    linkAddr <= ~a; // released lines show the inverse
    linkWrData <= ~d;
    n = 0;
    do begin
      @(negedge linkClk);
      n++;
    end while (linkBusy !== 1'b0 && n < 100);
    q = linkRdData;
  endtask
endmodule

// ---- verification/swdst_top_assertions.sv ----
// port checker for the supervisor timer, bound into the top
module swdst_top_assertions #(
  parameter int TICK_CYCLES = 10,
  parameter int HOLD_MS     = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic linkResetn,
  input wire logic linkWrEn,
  input wire logic linkRdEn,
  input wire logic linkBusy,
  input wire logic linkRdValid,
  input wire logic vccUnderVoltage,
  input wire logic batteryOverVoltage,
  input wire logic hostResetOut,
  input wire logic hostResetOe,
  input wire logic loadDriveEnable,
  input wire logic openLoadDetectEnable
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HoldLo = (HOLD_MS - 1) * TICK_CYCLES;
  localparam int HoldHi = (HOLD_MS + 1) * TICK_CYCLES + 8;
  int holdCnt_q;
  // cycles of host reset held so far
  always_ff @(posedge ref_clk) begin
    if (!resetn || !hostResetOe) begin
      holdCnt_q <= 0;
    end else begin
      holdCnt_q <= holdCnt_q + 1;
    end
  end
  ////////////////////////////////////////
  a_boot_state: assert property (
    @(posedge ref_clk) disable iff (!resetn) $rose(resetn) |->
    hostResetOe && !loadDriveEnable && openLoadDetectEnable)
    else $error("outputs not in boot state");
  a_drive_off: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    hostResetOe && $past(hostResetOe) |-> !loadDriveEnable)
    else $error("driver on during host reset");
  a_hold_span: assert property (
    @(posedge ref_clk) disable iff (!resetn) $fell(hostResetOe) |->
    holdCnt_q >= HoldLo && holdCnt_q <= HoldHi)
    else $error("host reset hold length wrong");
  a_pulse_min: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(hostResetOe) |=> hostResetOe [*8])
    else $error("host reset pulse too short");
  a_pin_low: assert property (
    @(posedge ref_clk) disable iff (!resetn) hostResetOut == 1'b0)
    else $error("host reset data not low");
  a_uv_reset: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(vccUnderVoltage) |-> ##[1:10] hostResetOe)
    else $error("undervoltage gave no reset");
  a_ov_reset: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(batteryOverVoltage) |-> ##[1:10] hostResetOe)
    else $error("overvoltage gave no reset");
  a_take_busy: assert property (
    @(posedge linkClk) disable iff (!linkResetn)
    (linkWrEn || linkRdEn) && !linkBusy |=> linkBusy ##[1:40] !linkBusy)
    else $error("link request not served");
  a_rdv_pulse: assert property (
    @(posedge linkClk) disable iff (!linkResetn)
    linkRdValid |-> !linkBusy ##1 !linkRdValid)
    else $error("read valid not a single pulse");
  c_reset: cover property (@(posedge ref_clk) $rose(hostResetOe));
  c_read: cover property (@(posedge linkClk) linkRdValid);
  c_ov: cover property (@(posedge ref_clk) $rose(batteryOverVoltage));
endmodule
bind swdst_top swdst_top_assertions #(
  .TICK_CYCLES(TICK_CYCLES), .HOLD_MS(HOLD_MS)) u_chk (
  .ref_clk, .resetn, .linkClk, .linkResetn, .linkWrEn, .linkRdEn,
  .linkBusy, .linkRdValid, .vccUnderVoltage, .batteryOverVoltage,
  .hostResetOut, .hostResetOe, .loadDriveEnable, .openLoadDetectEnable);

// ---- verification/tb_top.sv ----
// testbench for the supervisor timer
`include "swdst_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import swdst_pkg::*;
  localparam int TICK = 10;
  localparam int HOLD = 2;
  logic        ref_clk = 1'b0;
  logic        linkClk = 1'b0;
  logic        resetn = 1'b0;
  logic        linkResetn = 1'b0;
  logic        linkWrEn;
  logic        linkRdEn;
  swdst_idx_t  linkAddr;
  swdst_byte_t linkWrData;
  logic        linkBusy;
  logic        linkRdValid;
  swdst_byte_t linkRdData;
  swdst_byte_t faultIn = 8'h00;
  logic        vccUnderVoltage = 1'b0;
  logic        batteryOverVoltage = 1'b0;
  logic        hostResetOut;
  logic        hostResetOe;
  logic        loadDriveEnable;
  logic        openLoadDetectEnable;
  int          failCount = 0;
  int          nTests = 0;
  // core clock and unrelated link clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #1.7;
    forever #3 linkClk = ~linkClk;
  end
  swdst_top #(.TICK_CYCLES(TICK), .HOLD_MS(HOLD)) u_dut (
    .ref_clk, .resetn, .linkClk, .linkResetn, .linkWrEn, .linkRdEn,
    .linkAddr, .linkWrData, .linkBusy, .linkRdValid, .linkRdData,
    .faultIn, .vccUnderVoltage, .batteryOverVoltage, .hostResetOut,
    .hostResetOe, .loadDriveEnable, .openLoadDetectEnable);
  swdst_host_model u_host (.linkClk, .linkBusy, .linkRdData,
    .linkWrEn, .linkRdEn, .linkAddr, .linkWrData);
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_b(input swdst_byte_t got, input swdst_byte_t exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    nTests++;
    if (got < lo || got > hi) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input swdst_idx_t a, input swdst_byte_t d);
    swdst_byte_t q;
    u_host.xfer(1'b1, a, d, q);
    chk_b({7'h00, linkBusy}, 8'h00);
  endtask
  task automatic rd(input swdst_idx_t a, input swdst_byte_t exp);
    swdst_byte_t q;
    u_host.xfer(1'b0, a, 8'h00, q);
    chk_b({7'h00, linkRdValid}, 8'h01);
    chk_b(q, exp);
  endtask
  // core cycles until host reset asserts, capped
  task automatic until_rst(input int lim, output int n);
    n = 0;
    while (hostResetOe !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // hold length, then config back at default
  task automatic wait_rel();
    int n;
    n = 0;
    while (hostResetOe !== 1'b0 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk_n(n, (HOLD - 1) * TICK, (HOLD + 1) * TICK + 8);
    rd(`SWDST_IDX_CFG, `SWDST_CFG_RESET);
  endtask
  ////////////////////////////////////////
  task automatic t_boot();
    wait_rel();
    rd(`SWDST_IDX_WDCTRL, `SWDST_WDCTRL_RESET);
    rd(`SWDST_IDX_CTRL1, `SWDST_CTRL1_RESET);
    rd(`SWDST_IDX_STATUS, `SWDST_STATUS_RESET);
    chk_b({7'h00, openLoadDetectEnable}, 8'h01);
    chk_b({7'h00, loadDriveEnable}, 8'h00);
  endtask
  task automatic t_status_self_test();
    wr(`SWDST_IDX_CTRL1, 8'h40);
    @(posedge ref_clk) faultIn <= 8'h03;
    wr(`SWDST_IDX_STATUS, 8'hAA);
    rd(`SWDST_IDX_STATUS, 8'h2A);
    wr(`SWDST_IDX_STATUS, 8'h55);
    rd(`SWDST_IDX_STATUS, 8'h55);
    wr(`SWDST_IDX_STATUS, 8'hFF);
    rd(`SWDST_IDX_STATUS, 8'h7F);
    @(posedge ref_clk) faultIn <= 8'h00;
    wr(`SWDST_IDX_CTRL1, 8'h00);
    rd(`SWDST_IDX_STATUS, 8'h00);
    @(posedge ref_clk) faultIn <= 8'h05;
    repeat (10) @(posedge ref_clk);
    faultIn <= 8'h00;
    rd(`SWDST_IDX_STATUS, 8'h05);
    wr(`SWDST_IDX_STATUS, 8'hFB);
    rd(`SWDST_IDX_STATUS, 8'h01);
    wr(`SWDST_IDX_STATUS, 8'hFF);
    rd(`SWDST_IDX_STATUS, 8'h01);
  endtask
  task automatic t_rate();
    swdst_byte_t cfg [4] = '{8'h80, 8'h9F, 8'hB1, 8'h85};
    int ms [4] = '{1, 100, 100, 5};
    int n;
    foreach (cfg[i]) begin
      wr(`SWDST_IDX_CTRL1, 8'h40);
      wr(`SWDST_IDX_CFG, cfg[i]);
      wr(`SWDST_IDX_WDCTRL, 8'h80);
      until_rst(ms[i] * TICK + 40, n);
      chk_n(n, ms[i] * TICK - 16, ms[i] * TICK + 5);
      wait_rel();
      rd(`SWDST_IDX_CTRL1, 8'h00);
    end
  endtask
  task automatic t_oneshot();
    int n;
    wr(`SWDST_IDX_CFG, 8'h85);
    wr(`SWDST_IDX_WDCTRL, 8'h13);
    wr(`SWDST_IDX_WDCTRL, 8'h80);
    rd(`SWDST_IDX_WDCTRL, 8'h00);
    until_rst(400, n);
    chk_n(n, 260, 305);
    wait_rel();
    wr(`SWDST_IDX_CFG, 8'h85);
    wr(`SWDST_IDX_WDCTRL, 8'h80);
    wr(`SWDST_IDX_WDCTRL, 8'h13);
    until_rst(400, n);
    chk_n(n, 20, 55);
    wait_rel();
    wr(`SWDST_IDX_CFG, 8'h15);
    wr(`SWDST_IDX_WDCTRL, 8'h80);
    until_rst(800, n);
    chk_n(n, 800, 800);
  endtask
  task automatic t_soft();
    int n;
    wr(`SWDST_IDX_CTRL1, 8'h03);
    repeat (3) @(negedge ref_clk);
    chk_b({7'h00, loadDriveEnable}, 8'h01);
    chk_b({7'h00, openLoadDetectEnable}, 8'h00);
    wr(`SWDST_IDX_CTRL1, 8'h80);
    until_rst(30, n);
    chk_n(n, 30, 30);
    rd(`SWDST_IDX_CTRL1, 8'h00);
    rd(`SWDST_IDX_CFG, `SWDST_CFG_RESET);
    chk_b({7'h00, loadDriveEnable}, 8'h00);
    chk_b({7'h00, openLoadDetectEnable}, 8'h01);
  endtask
  task automatic t_supply();
    int n;
    for (int i = 0; i < 2; i++) begin
      wr(`SWDST_IDX_CFG, 8'h15);
      @(posedge ref_clk);
      vccUnderVoltage <= (i == 0);
      batteryOverVoltage <= (i == 1);
      until_rst(20, n);
      chk_n(n, 1, 12);
      @(posedge ref_clk);
      vccUnderVoltage <= 1'b0;
      batteryOverVoltage <= 1'b0;
      wait_rel();
    end
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge linkClk);
    linkResetn <= 1'b1;
    t_boot();
    t_status_self_test();
    t_rate();
    t_oneshot();
    t_soft();
    t_supply();
    print_verdict();
  end
  // hang guard
  initial begin
    #1ms;
    failCount++;
    print_verdict();
  end
endmodule
